//--- logic/panel_power_pkg.sv
package panel_power_pkg;
  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_QUARTER = 6'h09;
  localparam logic [5:0] IDX_RAIL = 6'h0a;
  localparam logic [5:0] IDX_AMPLITUDE = 6'h0b;
  localparam logic [5:0] IDX_CENTRE = 6'h0c;
  localparam logic [5:0] IDX_CMD_RESET = 6'h0f;
  localparam logic [5:0] IDX_CONV_ENABLE = 6'h18;
  localparam logic [5:0] IDX_STEP = 6'h19;
  localparam logic [5:0] IDX_OSCILLATION = 6'h1a;
  localparam logic [5:0] IDX_REGULATOR = 6'h1b;

  // ----------------------------------------------------------------
  // Writable bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_QUARTER = 8'h01;
  localparam logic [7:0] MASK_RAIL = 8'h03;
  localparam logic [7:0] MASK_AMPLITUDE = 8'h0f;
  localparam logic [7:0] MASK_CENTRE = 8'h7f;
  localparam logic [7:0] MASK_CONV_ENABLE = 8'h7d;
  localparam logic [7:0] MASK_STEP = 8'h1f;
  localparam logic [7:0] MASK_OSCILLATION = 8'hff;
  localparam logic [7:0] MASK_REGULATOR = 8'h7f;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CMD_RESET_BIT = 0;
  localparam int OSC_MID_DIV_LSB = 0;
  localparam int OSC_OTHER_DIV_LSB = 2;
  localparam int OSC_SOURCE_LSB = 4;
  localparam int OSC_DOUBLE_BIT = 7;

  // ----------------------------------------------------------------
  // Clock source codes and timing
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_OSC_12K5 = 3'h0;
  localparam logic [2:0] SRC_OSC_15K = 3'h1;
  localparam logic [2:0] SRC_OSC_20K = 3'h2;
  localparam logic [2:0] SRC_PIN = 3'h3;
  localparam logic [2:0] SRC_DOT_128 = 3'h4;
  localparam logic [2:0] SRC_DOT_256 = 3'h5;
  localparam int CLK_HZ = 10000000;
  localparam int OSC_HZ_12K5 = 12500;
  localparam int OSC_HZ_15K = 15000;
  localparam int OSC_HZ_20K = 20000;
  localparam logic [11:0] CYC_12K5 = 12'(CLK_HZ / OSC_HZ_12K5);
  localparam logic [11:0] CYC_15K = 12'(CLK_HZ / OSC_HZ_15K);
  localparam logic [11:0] CYC_20K = 12'(CLK_HZ / OSC_HZ_20K);
  localparam logic [8:0] DOT_DIV_128 = 9'h080;
  localparam logic [8:0] DOT_DIV_256 = 9'h100;
  localparam int PIXEL_W = 18;
endpackage

//--- logic/panel_power_config_regs.sv
`timescale 1ns/100ps
module panel_power_config_regs (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_wr_en,
  input wire logic [5:0] i_wr_index,
  input wire logic [7:0] i_wr_data,
  input wire logic [5:0] i_rd_index,
  input wire logic i_supply_low_power,
  input wire logic i_conv_clock_pin,
  input wire logic i_dot_clock,
  input wire logic i_pix_valid,
  input wire logic [17:0] i_pix_data,
  input wire logic i_line_start,
  output logic [7:0] o_rd_data,
  output logic o_gate_rail_vss1,
  output logic o_switch_rail_vss1,
  output logic [3:0] o_amplitude_code,
  output logic [6:0] o_centre_code,
  output logic o_converter_on,
  output logic o_positive_boost_on,
  output logic o_mid_boost_on,
  output logic o_neg1_boost_on,
  output logic o_neg2_boost_on,
  output logic o_ref_regulator_on,
  output logic o_boost_step_sel,
  output logic o_dual_boost_sel,
  output logic [2:0] o_ref_level_sel,
  output logic o_common_regulator_on,
  output logic [2:0] o_common_level_sel,
  output logic o_external_divider_sel,
  output logic [1:0] o_amp_bias_sel,
  output logic o_conv_clock_tick,
  output logic o_mid_boost_tick,
  output logic o_other_boost_tick,
  output logic o_pix_valid,
  output logic [17:0] o_pix_data,
  output logic o_gate_scan
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Whole bank in one record
  // Stored registers hold masked values only,
  // so prohibited bits can never reach a decode.
  // Counters and edge samples sit beside them,
  // which lets one reset clear everything at once.
  // Trade-off: a wide flop vector, but no
  // second process that could drift out of step.
  // Every output below is a slice of this record.
  typedef struct packed {
    logic [7:0] quarter_mode_reg;
    logic [7:0] rail_select_reg;
    logic [7:0] amplitude_reg;
    logic [7:0] centre_reg;
    logic [7:0] converter_enable_reg;
    logic [7:0] step_reg;
    logic [7:0] oscillation_reg;
    logic [7:0] regulator_reg;
    logic [7:0] rd_data;
    logic [11:0] osc_cnt;
    logic [8:0] dot_cnt;
    logic pin_prev;
    logic dot_prev;
    logic [3:0] div_cnt;
    logic conv_tick;
    logic mid_tick;
    logic other_tick;
    logic pix_valid;
    logic [17:0] pix_data;
    logic pix_repeat;
    logic [15:0] line_cnt;
    logic [15:0] half_len;
    logic gate_scan;
  } state_t;

  state_t st;
  state_t next_st;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Booster divide mask
  // Code n divides by 2 to the power n+1.
  // The tick fires when the masked count is zero,
  // so one shared counter serves both boosters.
  // Limitation: a code change mid-count may
  // give one short period before settling.
  function automatic logic [3:0] div_mask(input logic [1:0] code);
    div_mask = 4'((5'h02 << code) - 5'h01);
  endfunction

  // Read-back mux
  // Unmapped indices return zero.
  // The command reset never stores anything,
  // so it always reads as cleared.
  // Result is registered before leaving the block.
  function automatic logic [7:0] read_reg(input state_t s, input logic [5:0] idx);
    case (idx)
      panel_power_pkg::IDX_QUARTER: read_reg = s.quarter_mode_reg;
      panel_power_pkg::IDX_RAIL: read_reg = s.rail_select_reg;
      panel_power_pkg::IDX_AMPLITUDE: read_reg = s.amplitude_reg;
      panel_power_pkg::IDX_CENTRE: read_reg = s.centre_reg;
      panel_power_pkg::IDX_CONV_ENABLE: read_reg = s.converter_enable_reg;
      panel_power_pkg::IDX_STEP: read_reg = s.step_reg;
      panel_power_pkg::IDX_OSCILLATION: read_reg = s.oscillation_reg;
      panel_power_pkg::IDX_REGULATOR: read_reg = s.regulator_reg;
      default: read_reg = 8'h00; // Command reset reads back as cleared
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [2:0] src;
    logic dbl;
    logic [11:0] osc_period;
    logic [8:0] dot_period;
    logic osc_hit;
    logic src_tick;
    logic [3:0] div_now;
    logic quarter;
    src = st.oscillation_reg[panel_power_pkg::OSC_SOURCE_LSB +: 3];
    dbl = st.oscillation_reg[panel_power_pkg::OSC_DOUBLE_BIT];
    osc_period = panel_power_pkg::CYC_12K5;
    dot_period = panel_power_pkg::DOT_DIV_128;
    osc_hit = 1'b0;
    src_tick = 1'b0;
    div_now = st.div_cnt;
    quarter = st.quarter_mode_reg[0];
    next_st = st;

    // Register writes over the serial port, prohibited bits dropped
    if (i_wr_en)
    begin
      case (i_wr_index)
        panel_power_pkg::IDX_QUARTER:
          next_st.quarter_mode_reg = i_wr_data & panel_power_pkg::MASK_QUARTER;
        panel_power_pkg::IDX_RAIL:
          next_st.rail_select_reg = i_wr_data & panel_power_pkg::MASK_RAIL;
        panel_power_pkg::IDX_AMPLITUDE:
          next_st.amplitude_reg = i_wr_data & panel_power_pkg::MASK_AMPLITUDE;
        panel_power_pkg::IDX_CENTRE:
          next_st.centre_reg = i_wr_data & panel_power_pkg::MASK_CENTRE;
        panel_power_pkg::IDX_CONV_ENABLE:
          next_st.converter_enable_reg = i_wr_data & panel_power_pkg::MASK_CONV_ENABLE;
        panel_power_pkg::IDX_STEP:
          next_st.step_reg = i_wr_data & panel_power_pkg::MASK_STEP;
        panel_power_pkg::IDX_OSCILLATION:
          next_st.oscillation_reg = i_wr_data & panel_power_pkg::MASK_OSCILLATION;
        panel_power_pkg::IDX_REGULATOR:
          next_st.regulator_reg = i_wr_data & panel_power_pkg::MASK_REGULATOR;
        panel_power_pkg::IDX_CMD_RESET:
        begin
          // Only bit 0 acts; nothing is stored, so the bit clears itself
          if (i_wr_data[panel_power_pkg::CMD_RESET_BIT])
          begin
            next_st.quarter_mode_reg = panel_power_pkg::RESET_VALUE;
            next_st.rail_select_reg = panel_power_pkg::RESET_VALUE;
            next_st.amplitude_reg = panel_power_pkg::RESET_VALUE;
            next_st.centre_reg = panel_power_pkg::RESET_VALUE;
            next_st.converter_enable_reg = panel_power_pkg::RESET_VALUE;
            next_st.step_reg = panel_power_pkg::RESET_VALUE;
            next_st.oscillation_reg = panel_power_pkg::RESET_VALUE;
            next_st.regulator_reg = panel_power_pkg::RESET_VALUE;
          end
        end
        default: ;
      endcase
    end
    next_st.rd_data = read_reg(st, i_rd_index);

    // Converter clock period selection
    // Internal rates come from the system clock
    // by whole-cycle division, so each rate is
    // approximate to within one system cycle.
    // Source and doubling act from the cycle
    // after the write, with no glitch guard.
    // Internal oscillator period; doubling halves it
    case (src)
      panel_power_pkg::SRC_OSC_15K: osc_period = panel_power_pkg::CYC_15K;
      panel_power_pkg::SRC_OSC_20K: osc_period = panel_power_pkg::CYC_20K;
      default: osc_period = panel_power_pkg::CYC_12K5;
    endcase
    if (dbl)
    begin
      osc_period = osc_period >> 1;
    end
    dot_period = (src == panel_power_pkg::SRC_DOT_256) ? panel_power_pkg::DOT_DIV_256
                                                      : panel_power_pkg::DOT_DIV_128;
    if (dbl)
    begin
      dot_period = dot_period >> 1;
    end

    // Oscillator counter; a shortened period restarts it cleanly
    if (st.osc_cnt >= osc_period - 12'h001)
    begin
      next_st.osc_cnt = 12'h000;
      osc_hit = 1'b1;
    end
    else
    begin
      next_st.osc_cnt = st.osc_cnt + 12'h001;
    end

    // Edge samples of the slow clocks
    // Both pins are treated as synchronous inputs;
    // a pin faster than half the system clock
    // would lose edges here.
    // Edge counts restart only at the wrap point.
    // Dot clock edge counter
    next_st.pin_prev = i_conv_clock_pin;
    next_st.dot_prev = i_dot_clock;
    if (i_dot_clock && !st.dot_prev)
    begin
      if (9'(st.dot_cnt + 9'h001) >= dot_period)
      begin
        next_st.dot_cnt = 9'h000;
      end
      else
      begin
        next_st.dot_cnt = st.dot_cnt + 9'h001;
      end
    end

    // Source selection of the converter clock
    case (src)
      panel_power_pkg::SRC_OSC_12K5,
      panel_power_pkg::SRC_OSC_15K,
      panel_power_pkg::SRC_OSC_20K: src_tick = osc_hit;
      panel_power_pkg::SRC_PIN: src_tick = i_conv_clock_pin && !st.pin_prev;
      panel_power_pkg::SRC_DOT_128,
      panel_power_pkg::SRC_DOT_256:
        src_tick = i_dot_clock && !st.dot_prev && (9'(st.dot_cnt + 9'h001) >= dot_period);
      default: src_tick = 1'b0; // Unused codes stop the converter clock
    endcase
    next_st.conv_tick = src_tick;

    // Booster tick generation
    // The shared count keeps running in low-power
    // mode so normal rates resume in phase.
    // Low-power rates are set elsewhere and
    // are not produced by this bank.
    // Booster dividers, silent in supply low-power mode
    next_st.mid_tick = 1'b0;
    next_st.other_tick = 1'b0;
    if (src_tick)
    begin
      div_now = st.div_cnt + 4'h1;
      next_st.div_cnt = div_now;
      if (!i_supply_low_power)
      begin
        next_st.mid_tick = (div_now & div_mask(st.oscillation_reg[1:0])) == 4'h0;
        next_st.other_tick = (div_now & div_mask(st.oscillation_reg[3:2])) == 4'h0;
      end
    end

    // Pixel path: quarter mode emits each pixel a second time
    next_st.pix_valid = 1'b0;
    next_st.pix_repeat = 1'b0;
    if (i_pix_valid)
    begin
      next_st.pix_valid = 1'b1;
      next_st.pix_data = i_pix_data;
      next_st.pix_repeat = quarter;
    end
    else if (st.pix_repeat)
    begin
      next_st.pix_valid = 1'b1;
    end

    // Line timing for the doubled scan
    // Mid point comes from the previous line length,
    // so the first line after a mode change
    // may place its second scan off centre.
    // Count saturates, avoiding a false mid scan
    // when line starts stop arriving.
    // Gate scan: quarter mode adds a scan at mid line
    next_st.gate_scan = 1'b0;
    if (i_line_start)
    begin
      next_st.gate_scan = 1'b1;
      next_st.half_len = 16'(st.line_cnt >> 1);
      next_st.line_cnt = 16'h0000;
    end
    else
    begin
      if (st.line_cnt != 16'hffff)
      begin
        next_st.line_cnt = st.line_cnt + 16'h0001;
      end
      if (quarter && st.half_len != 16'h0000 && st.line_cnt == st.half_len)
      begin
        next_st.gate_scan = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Single clocked process for the whole record
  // Asynchronous reset loads constants only;
  // command reset goes through the next-state path
  // so it stays a normal synchronous write.
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Decoded outputs, all straight from state flops
  // ----------------------------------------------------------------
  assign o_rd_data = st.rd_data;
  assign o_gate_rail_vss1 = st.rail_select_reg[0];
  assign o_switch_rail_vss1 = st.rail_select_reg[1];
  assign o_amplitude_code = st.amplitude_reg[3:0];
  assign o_centre_code = st.centre_reg[6:0];
  assign o_converter_on = st.converter_enable_reg[0];
  assign o_positive_boost_on = st.converter_enable_reg[2];
  assign o_mid_boost_on = st.converter_enable_reg[3];
  assign o_neg1_boost_on = st.converter_enable_reg[4];
  assign o_neg2_boost_on = st.converter_enable_reg[5];
  assign o_ref_regulator_on = st.converter_enable_reg[6];
  assign o_boost_step_sel = st.step_reg[0];
  assign o_dual_boost_sel = st.step_reg[1];
  assign o_ref_level_sel = st.step_reg[4:2];
  assign o_common_regulator_on = st.regulator_reg[0];
  assign o_common_level_sel = st.regulator_reg[3:1];
  assign o_external_divider_sel = st.regulator_reg[4];
  assign o_amp_bias_sel = st.regulator_reg[6:5];
  assign o_conv_clock_tick = st.conv_tick;
  assign o_mid_boost_tick = st.mid_tick;
  assign o_other_boost_tick = st.other_tick;
  assign o_pix_valid = st.pix_valid;
  assign o_pix_data = st.pix_data;
  assign o_gate_scan = st.gate_scan;
endmodule

//--- testbench/panel_power_host.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Host side: register writes into the bank
// ------------------------------------------------------------
module panel_power_host (
  input wire logic i_clk_sys,
  output logic o_wr_en,
  output logic [5:0] o_wr_index,
  output logic [7:0] o_wr_data
);
  // Idle bus before the first write
  initial
  begin
    o_wr_en = 1'b0;
    o_wr_index = 6'h00;
    o_wr_data = 8'h00;
  end

  // One write, called at a rising edge; lines are scrambled after release
  task automatic write(input logic [5:0] idx, input logic [7:0] data);
    o_wr_en <= 1'b1;
    o_wr_index <= idx;
    o_wr_data <= data;
    @(posedge i_clk_sys);
    o_wr_en <= 1'b0;
    o_wr_index <= ~idx;
    o_wr_data <= ~data;
  endtask
endmodule

//--- testbench/panel_power_config_regs_assertions.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Port checks of the configuration bank
// ------------------------------------------------------------
module panel_power_config_regs_assertions (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_wr_en,
  input wire logic [5:0] i_wr_index,
  input wire logic [7:0] i_wr_data,
  input wire logic i_pix_valid,
  input wire logic [17:0] i_pix_data,
  input wire logic o_gate_rail_vss1,
  input wire logic o_switch_rail_vss1,
  input wire logic [3:0] o_amplitude_code,
  input wire logic [6:0] o_centre_code,
  input wire logic o_converter_on,
  input wire logic o_positive_boost_on,
  input wire logic o_mid_boost_on,
  input wire logic o_neg1_boost_on,
  input wire logic o_neg2_boost_on,
  input wire logic o_ref_regulator_on,
  input wire logic o_boost_step_sel,
  input wire logic o_dual_boost_sel,
  input wire logic [2:0] o_ref_level_sel,
  input wire logic o_common_regulator_on,
  input wire logic [2:0] o_common_level_sel,
  input wire logic o_external_divider_sel,
  input wire logic [1:0] o_amp_bias_sel,
  input wire logic o_pix_valid,
  input wire logic [17:0] o_pix_data
);
  logic [7:0] last_data;
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);
  // Write data one edge back, so decodes compare without $past slices
  always_ff @(posedge i_clk_sys)
    last_data <= i_wr_data;
  // One write taken at this edge
  sequence wr_s(logic [5:0] idx);
    i_wr_en && i_wr_index == idx;
  endsequence
  chk_gate_rail: assert property (
    wr_s(panel_power_pkg::IDX_RAIL) |=> o_gate_rail_vss1 == last_data[0])
    else $error("gate rail does not follow write");
  chk_switch_rail: assert property (
    wr_s(panel_power_pkg::IDX_RAIL) |=> o_switch_rail_vss1 == last_data[1])
    else $error("switch rail does not follow write");
  chk_amp_code: assert property (
    wr_s(panel_power_pkg::IDX_AMPLITUDE) |=> o_amplitude_code == last_data[3:0])
    else $error("amplitude code wrong");
  chk_centre_code: assert property (
    wr_s(panel_power_pkg::IDX_CENTRE) |=> o_centre_code == last_data[6:0])
    else $error("centre code wrong");
  chk_cmd_clear: assert property (
    wr_s(panel_power_pkg::IDX_CMD_RESET) ##0 i_wr_data[0] |=> o_amplitude_code == 4'h0
    && o_centre_code == 7'h00 && !o_gate_rail_vss1 && !o_converter_on)
    else $error("command reset left state");
  chk_cmd_ignore: assert property (
    wr_s(panel_power_pkg::IDX_CMD_RESET) ##0 !i_wr_data[0] |=> $stable(o_centre_code))
    else $error("ignored reset bits acted");
  chk_conv_enables: assert property (
    wr_s(panel_power_pkg::IDX_CONV_ENABLE) |=> {o_ref_regulator_on, o_neg2_boost_on,
    o_neg1_boost_on, o_mid_boost_on, o_positive_boost_on, o_converter_on}
    == {last_data[6:2], last_data[0]}) else $error("enable decode wrong");
  chk_step_fields: assert property (
    wr_s(panel_power_pkg::IDX_STEP) |=> {o_ref_level_sel, o_dual_boost_sel,
    o_boost_step_sel} == last_data[4:0]) else $error("step decode wrong");
  chk_reg_fields: assert property (
    wr_s(panel_power_pkg::IDX_REGULATOR) |=> {o_amp_bias_sel, o_external_divider_sel,
    o_common_level_sel, o_common_regulator_on} == last_data[6:0])
    else $error("regulator decode wrong");
  chk_pix_echo: assert property (
    i_pix_valid |=> o_pix_valid && o_pix_data == $past(i_pix_data))
    else $error("pixel not passed on");
endmodule

bind panel_power_config_regs panel_power_config_regs_assertions chk_i (.*);

//--- testbench/tb.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Self-checking bench of the configuration bank
// ------------------------------------------------------------
module tb;
  logic i_clk_sys = 1'b0;
  logic i_resetn, i_wr_en, i_supply_low_power, i_conv_clock_pin, i_dot_clock;
  logic i_pix_valid, i_line_start, o_gate_rail_vss1, o_switch_rail_vss1, o_converter_on;
  logic o_positive_boost_on, o_mid_boost_on, o_neg1_boost_on, o_neg2_boost_on;
  logic o_ref_regulator_on, o_boost_step_sel, o_dual_boost_sel, o_common_regulator_on;
  logic o_external_divider_sel, o_conv_clock_tick, o_mid_boost_tick, o_other_boost_tick;
  logic o_pix_valid, o_gate_scan;
  logic [5:0] i_wr_index, i_rd_index;
  logic [7:0] i_wr_data, o_rd_data;
  logic [17:0] i_pix_data, o_pix_data, px;
  logic [3:0] o_amplitude_code;
  logic [6:0] o_centre_code;
  logic [2:0] o_ref_level_sel, o_common_level_sel;
  logic [1:0] o_amp_bias_sel;
  logic [31:0] seed = 32'h6;
  int model [64];
  int idxs [8] = '{10, 11, 12, 24, 25, 26, 27, 9};
  logic [7:0] msk [8] = '{8'h03, 8'h0f, 8'h7f, 8'h7d, 8'h1f, 8'hff, 8'h7f, 8'h01};
  int bad_count = 0;
  int cmp_count = 0;
  int ct, mt, ot, cnt;

  always #50 i_clk_sys = ~i_clk_sys;

  panel_power_config_regs panel_power_config_regs_i (.*);
  panel_power_host panel_power_host_i (.i_clk_sys(i_clk_sys), .o_wr_en(i_wr_en),
    .o_wr_index(i_wr_index), .o_wr_data(i_wr_data));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Write and mirror it; command reset bit 0 wipes the mirror
  task automatic wr(input int idx, input logic [7:0] data, input logic [7:0] m);
    panel_power_host_i.write(6'(idx), data);
    model[idx] = int'(data & m);
    if (idx == 15 && data[0])
      model = '{default: 0};
  endtask

  // Decoded outputs against the mirror, sampled mid-cycle
  task automatic check_all();
    @(negedge i_clk_sys);
    chk(19'({o_switch_rail_vss1, o_gate_rail_vss1}), 19'(model[10]));
    chk(19'(o_amplitude_code), 19'(model[11]));
    chk(19'(o_centre_code), 19'(model[12]));
    chk(19'({o_ref_regulator_on, o_neg2_boost_on, o_neg1_boost_on}), 19'(model[24] >> 4));
    chk(19'({o_mid_boost_on, o_positive_boost_on, o_converter_on}), 19'(model[24] >> 1 & 6 | model[24] & 1));
    chk(19'({o_ref_level_sel, o_dual_boost_sel, o_boost_step_sel}), 19'(model[25]));
    chk(19'({o_amp_bias_sel, o_external_divider_sel}), 19'(model[27] >> 4));
    chk(19'({o_common_level_sel, o_common_regulator_on}), 19'(model[27] & 15));
    @(posedge i_clk_sys);
  endtask

  task automatic rd_chk(input int idx);
    i_rd_index <= 6'(idx);
    @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk(19'(o_rd_data), 19'(model[idx]));
    @(posedge i_clk_sys);
  endtask

  // Edges on the pin or dot clock, counting the three tick outputs
  task automatic run_src(input int n, input bit on_dot);
    ct = 0;
    mt = 0;
    ot = 0;
    repeat (2 * n)
    begin
      if (on_dot)
        i_dot_clock <= ~i_dot_clock;
      else
        i_conv_clock_pin <= ~i_conv_clock_pin;
      repeat (2)
      begin
        @(negedge i_clk_sys);
        ct += int'(o_conv_clock_tick === 1'b1);
        mt += int'(o_mid_boost_tick === 1'b1);
        ot += int'(o_other_boost_tick === 1'b1);
        @(posedge i_clk_sys);
      end
    end
  endtask

  task automatic final_report();
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog: a run that overstays counts as a failure
  initial
  begin
    repeat (30000) @(posedge i_clk_sys);
    bad_count++;
    final_report();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    i_resetn = 1'b0;
    i_supply_low_power = 1'b0;
    i_conv_clock_pin = 1'b0;
    i_dot_clock = 1'b0;
    i_pix_valid = 1'b0;
    i_pix_data = 18'h00000;
    i_line_start = 1'b0;
    i_rd_index = 6'h00;
    repeat (10) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    check_all();
    for (int n = 0; n < 24; n++)
    begin
      wr(idxs[n % 8], 8'(xs()), msk[n % 8]);
      check_all();
    end
    foreach (idxs[k])
      rd_chk(idxs[k]);
    rd_chk(32);
    wr(15, 8'hfe, 8'h00);
    check_all();
    wr(15, 8'h01, 8'h00);
    check_all();
    rd_chk(15);
    // Quarter mode first, then normal: pixel repeat and double scan
    for (int m = 1; m >= 0; m--)
    begin
      wr(9, 8'(m), 8'h01);
      check_all();
      // Single pixel per line here; a full quarter line is 120 pixels
      px = 18'(xs());
      i_pix_data <= px;
      i_pix_valid <= 1'b1;
      @(posedge i_clk_sys);
      i_pix_valid <= 1'b0;
      i_pix_data <= ~px;
      @(negedge i_clk_sys);
      chk({o_pix_valid, o_pix_data}, {1'b1, px});
      @(negedge i_clk_sys);
      chk({o_pix_valid, o_pix_data & {18{m[0]}}}, {m[0], px & {18{m[0]}}});
      repeat (2)
      begin
        @(posedge i_clk_sys);
        i_line_start <= 1'b1;
        cnt = 0;
        repeat (40)
        begin
          @(posedge i_clk_sys);
          i_line_start <= 1'b0;
          @(negedge i_clk_sys);
          cnt += int'(o_gate_scan === 1'b1);
        end
      end
      @(posedge i_clk_sys);
      chk(19'(cnt), 19'(m + 1));
    end
    // Internal oscillator, plain then doubled, over 800 cycles
    for (int k = 0; k < 2; k++)
    begin
      wr(26, 8'(k << 7), 8'hff);
      check_all();
      run_src(200, 1'b0);
      chk(19'(ct), 19'(k + 1));
    end
    wr(26, 8'h34, 8'hff);
    check_all();
    run_src(8, 1'b0);
    chk(19'({ct[7:0], mt[3:0], ot[3:0]}), 19'h00842);
    i_supply_low_power <= 1'b1;
    run_src(8, 1'b0);
    chk(19'(mt + ot), 19'h0);
    wr(26, 8'hc0, 8'hff);
    check_all();
    run_src(128, 1'b1);
    chk(19'(ct), 19'h2);
    final_report();
  end
endmodule
